// file: logic/display_ram_access_control.sv
`timescale 1ns/1ps
module display_ram_access_control
  import disp_ram_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  input wire logic [6:0] scanRowOut,
  input wire logic [5:0] scanCol,
  output logic [7:0] scanPixel,
  output logic scanRowActive,
  output logic [7:0] contrastLevel,
  output logic scrollRunning
);

  logic [7:0] pixelRam [0:8191];
  logic accept, rdStep, cmdWr, dataWr, cfgWr, ptrStep, colLoad, rowLoad, frameTick, inWin;
  logic [7:0] wrByte, ramRdByte, scanColMapped, unusedSize;
  logic [5:0] colPtr, srcCol;
  logic [6:0] rowPtr, mapRow, winW, rel, sum, offInc;
  logic mapActive;

  logic wrPend_r, wrPend_nxt;
  logic [7:0] wrAddr_r, wrAddr_nxt, readLatch_r, readLatch_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  cmd_state_t state_r, state_nxt;
  logic [7:0] opcode_r, opcode_nxt, argHold_r, argHold_nxt, contrast_r, contrast_nxt;
  logic [7:0] remap_r, remap_nxt;
  logic [2:0] argIdx_r, argIdx_nxt, argLast_r, argLast_nxt, sInterval_r, sInterval_nxt;
  logic [6:0] startLine_r, startLine_nxt, activeRows_r, activeRows_nxt;
  logic [6:0] sStartRow_r, sStartRow_nxt, sEndRow_r, sEndRow_nxt;
  logic [5:0] sStartCol_r, sStartCol_nxt, sEndCol_r, sEndCol_nxt;
  logic scrollLeft_r, scrollLeft_nxt, scrollArmed_r, scrollArmed_nxt;
  logic scrollOn_r, scrollOn_nxt, serialMode_r, serialMode_nxt, scrollGo;

  logic [16:0] frameDiv_r, frameDiv_nxt;
  logic [8:0] frameCnt_r, frameCnt_nxt;
  logic [5:0] scrollOff_r, scrollOff_nxt;
  logic [7:0] scanPixel_r, scanPixel_nxt;
  logic scanActive_r, scanActive_nxt;

  // ****************************************************************
  // AHB-Lite front end
  // ****************************************************************
  // Every transfer finishes without wait states and always answers OKAY.
  assign accept = hsel && hready && htrans[1];
  assign wrByte = hwdata[7:0];
  assign unusedSize = {5'h00, hsize};
  assign cmdWr = wrPend_r && (wrAddr_r == OFS_CMD);
  assign dataWr = wrPend_r && (wrAddr_r == OFS_DATA);
  assign cfgWr = wrPend_r && (wrAddr_r == OFS_CONFIG);
  // Serial mode has no read path, so a data read there is inert.
  assign rdStep = accept && !hwrite && (haddr[7:0] == OFS_DATA) && !serialMode_r;
  assign ptrStep = dataWr || rdStep;
  assign ramRdByte = nibble_map(pixelRam[{rowPtr, colPtr}], remap_r[REMAP_NIBBLE_BIT]);

  // Read side effects happen in the address phase; writes land in the data phase.
  always_comb
  begin
    wrPend_nxt = accept && hwrite;
    wrAddr_nxt = accept ? haddr[7:0] : wrAddr_r;
    readLatch_nxt = rdStep ? ramRdByte : readLatch_r;
    hrdata_nxt = hrdata_r;
    if (accept && !hwrite)
    begin
      unique case (haddr[7:0])
        OFS_DATA: hrdata_nxt = serialMode_r ? 32'h0 : {24'h0, readLatch_r};
        OFS_STATUS: hrdata_nxt = {9'h0, rowPtr, 2'h0, colPtr, 5'h0, scrollArmed_r,
                                  state_r == CMD_ARGS, scrollOn_r};
        OFS_CONFIG: hrdata_nxt = {31'h0, serialMode_r};
        OFS_SETUP: hrdata_nxt = {1'b0, activeRows_r, 1'b0, startLine_r, remap_r, contrast_r};
        default: hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      readLatch_r <= 8'h00;
      hrdata_r <= 32'h0;
    end
    else
    begin
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      readLatch_r <= readLatch_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Pixel storage has no reset; its content is whatever the host wrote.
  always_ff @(posedge core_clk)
  begin
    if (dataWr)
    begin
      pixelRam[{rowPtr, colPtr}] <= nibble_map(wrByte, remap_r[REMAP_NIBBLE_BIT]);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_r;

  // ****************************************************************
  // Command interpreter
  // ****************************************************************
  // Argument bytes arrive through the command register, like the opcode.
  always_comb
  begin
    state_nxt = state_r;
    opcode_nxt = opcode_r;
    argIdx_nxt = argIdx_r;
    argLast_nxt = argLast_r;
    argHold_nxt = argHold_r;
    contrast_nxt = contrast_r;
    remap_nxt = remap_r;
    startLine_nxt = startLine_r;
    activeRows_nxt = activeRows_r;
    sStartRow_nxt = sStartRow_r;
    sEndRow_nxt = sEndRow_r;
    sInterval_nxt = sInterval_r;
    sStartCol_nxt = sStartCol_r;
    sEndCol_nxt = sEndCol_r;
    scrollLeft_nxt = scrollLeft_r;
    scrollArmed_nxt = scrollArmed_r;
    scrollOn_nxt = scrollOn_r;
    serialMode_nxt = cfgWr ? wrByte[0] : serialMode_r;
    colLoad = 1'b0;
    rowLoad = 1'b0;
    scrollGo = 1'b0;
    if (cmdWr && state_r == CMD_OPCODE)
    begin
      opcode_nxt = wrByte;
      argIdx_nxt = 3'h0;
      scrollArmed_nxt = 1'b0;
      unique case (wrByte)
        OP_COL_ADDR, OP_ROW_ADDR:
        begin
          argLast_nxt = ARGS_ADDR - 3'h1;
          state_nxt = CMD_ARGS;
        end
        OP_CONTRAST, OP_REMAP, OP_START_LINE, OP_ROW_COUNT:
        begin
          argLast_nxt = ARGS_ONE - 3'h1;
          state_nxt = CMD_ARGS;
        end
        OP_SCROLL_RIGHT, OP_SCROLL_LEFT:
        begin
          argLast_nxt = ARGS_SCROLL - 3'h1;
          state_nxt = CMD_ARGS;
        end
        OP_SCROLL_STOP: scrollOn_nxt = 1'b0;
        OP_SCROLL_GO:
        begin
          scrollOn_nxt = scrollArmed_r || scrollOn_r;
          scrollGo = scrollArmed_r;
        end
        default: state_nxt = CMD_OPCODE;
      endcase
    end
    else if (cmdWr)
    begin
      argIdx_nxt = argIdx_r + 3'h1;
      argHold_nxt = wrByte;
      unique case (opcode_r)
        OP_COL_ADDR: colLoad = (argIdx_r == argLast_r);
        OP_ROW_ADDR: rowLoad = (argIdx_r == argLast_r);
        OP_CONTRAST: contrast_nxt = wrByte;
        OP_REMAP: remap_nxt = wrByte;
        OP_START_LINE: startLine_nxt = wrByte[6:0];
        OP_ROW_COUNT: activeRows_nxt = wrByte[6:0];
        default:
        begin
          // Bytes 0 and 6 of the scroll setup are dummies and are dropped.
          unique case (argIdx_r)
            SC_START_ROW: sStartRow_nxt = wrByte[6:0];
            SC_INTERVAL: sInterval_nxt = wrByte[2:0];
            SC_END_ROW: sEndRow_nxt = wrByte[6:0];
            SC_START_COL: sStartCol_nxt = wrByte[5:0];
            SC_END_COL: sEndCol_nxt = wrByte[5:0];
            default: sEndCol_nxt = sEndCol_r;
          endcase
          scrollLeft_nxt = opcode_r[0];
          scrollArmed_nxt = (argIdx_r == argLast_r);
        end
      endcase
      if (argIdx_r == argLast_r)
      begin
        state_nxt = CMD_OPCODE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= CMD_OPCODE;
      opcode_r <= 8'h00;
      argIdx_r <= 3'h0;
      argLast_r <= 3'h0;
      argHold_r <= 8'h00;
      contrast_r <= CONTRAST_RST;
      remap_r <= REMAP_RST;
      startLine_r <= START_LINE_RST;
      activeRows_r <= ROW_COUNT_RST;
      sStartRow_r <= ROW_START_RST;
      sEndRow_r <= ROW_END_RST;
      sInterval_r <= INTERVAL_RST;
      sStartCol_r <= COL_START_RST;
      sEndCol_r <= COL_END_RST;
      scrollLeft_r <= 1'b0;
      scrollArmed_r <= 1'b0;
      scrollOn_r <= 1'b0;
      serialMode_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      opcode_r <= opcode_nxt;
      argIdx_r <= argIdx_nxt;
      argLast_r <= argLast_nxt;
      argHold_r <= argHold_nxt;
      contrast_r <= contrast_nxt;
      remap_r <= remap_nxt;
      startLine_r <= startLine_nxt;
      activeRows_r <= activeRows_nxt;
      sStartRow_r <= sStartRow_nxt;
      sEndRow_r <= sEndRow_nxt;
      sInterval_r <= sInterval_nxt;
      sStartCol_r <= sStartCol_nxt;
      sEndCol_r <= sEndCol_nxt;
      scrollLeft_r <= scrollLeft_nxt;
      scrollArmed_r <= scrollArmed_nxt;
      scrollOn_r <= scrollOn_nxt;
      serialMode_r <= serialMode_nxt;
    end
  end

  addr_pointer u_addr_pointer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .setCol(colLoad),
    .setRow(rowLoad),
    .startIn(argHold_r[6:0]),
    .endIn(wrByte[6:0]),
    .step(ptrStep),
    .vertical(remap_r[REMAP_VERT_BIT]),
    .colPtr(colPtr),
    .rowPtr(rowPtr)
  );

  // ****************************************************************
  // Scroll timing and scan read-out
  // ****************************************************************
  // Scrolling is modelled as a rotating column offset applied at read-out,
  // so the stored pixels stay put; a stop shows the unscrolled image again without a rewrite.
  assign frameTick = (frameDiv_r == 17'(FRAME_CYCLES - 1));
  assign winW = {1'b0, sEndCol_r} - {1'b0, sStartCol_r} + 7'h01;
  assign offInc = {1'b0, scrollOff_r} + 7'h01;
  assign scanColMapped = {2'h0, remap_r[REMAP_COL_BIT] ? ~scanCol : scanCol};
  assign rel = 7'(scanColMapped - {2'h0, sStartCol_r});

  always_comb
  begin
    frameDiv_nxt = frameTick ? 17'h0 : frameDiv_r + 17'h1;
    frameCnt_nxt = frameCnt_r;
    scrollOff_nxt = scrollOff_r;
    if (scrollGo)
    begin
      frameCnt_nxt = 9'h0;
      scrollOff_nxt = 6'h00;
    end
    else if (scrollOn_r && frameTick)
    begin
      frameCnt_nxt = frameCnt_r + 9'h1;
      if (frameCnt_r >= scroll_frames(sInterval_r) - 9'h1)
      begin
        frameCnt_nxt = 9'h0;
        if (scrollLeft_r)
        begin
          scrollOff_nxt = (offInc >= winW) ? 6'h00 : offInc[5:0];
        end
        else
        begin
          scrollOff_nxt = (scrollOff_r == 6'h00) ? 6'(winW - 7'h01) : scrollOff_r - 6'h01;
        end
      end
    end
    inWin = scrollOn_r && mapRow >= sStartRow_r && mapRow <= sEndRow_r &&
            scanColMapped[5:0] >= sStartCol_r && scanColMapped[5:0] <= sEndCol_r;
    sum = rel + {1'b0, scrollOff_r};
    if (sum >= winW)
    begin
      sum = sum - winW;
    end
    srcCol = inWin ? sStartCol_r + sum[5:0] : scanColMapped[5:0];
    scanActive_nxt = mapActive;
    scanPixel_nxt = mapActive ? pixelRam[{mapRow, srcCol}] : 8'h00;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frameDiv_r <= 17'h0;
      frameCnt_r <= 9'h0;
      scrollOff_r <= 6'h00;
      scanPixel_r <= 8'h00;
      scanActive_r <= 1'b0;
    end
    else
    begin
      frameDiv_r <= frameDiv_nxt;
      frameCnt_r <= frameCnt_nxt;
      scrollOff_r <= scrollOff_nxt;
      scanPixel_r <= scanPixel_nxt;
      scanActive_r <= scanActive_nxt;
    end
  end

  row_map u_row_map (
    .rowOut(scanRowOut),
    .activeRows(activeRows_r),
    .startLine(startLine_r),
    .rowReverse(remap_r[REMAP_ROWREV_BIT]),
    .oddEvenSplit(remap_r[REMAP_SPLIT_BIT]),
    .ramRow(mapRow),
    .rowActive(mapActive)
  );

  assign scanPixel = scanPixel_r;
  assign scanRowActive = scanActive_r;
  assign contrastLevel = contrast_r;
  assign scrollRunning = scrollOn_r;

endmodule : display_ram_access_control

// file: logic/disp_ram_pkg.sv
package disp_ram_pkg;

  // ****************************************************************
  // Register map, byte addresses on the AHB-Lite slave
  // ****************************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_SETUP = 8'h10;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // ****************************************************************
  // Command opcodes
  // ****************************************************************
  localparam logic [7:0] OP_COL_ADDR = 8'h15;
  localparam logic [7:0] OP_ROW_ADDR = 8'h75;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_NOP_LO = 8'h84;
  localparam logic [7:0] OP_NOP_HI = 8'h86;
  localparam logic [7:0] OP_REMAP = 8'ha0;
  localparam logic [7:0] OP_START_LINE = 8'ha1;
  localparam logic [7:0] OP_ROW_COUNT = 8'ha8;
  localparam logic [7:0] OP_SCROLL_RIGHT = 8'h26;
  localparam logic [7:0] OP_SCROLL_LEFT = 8'h27;
  localparam logic [7:0] OP_SCROLL_STOP = 8'h2e;
  localparam logic [7:0] OP_SCROLL_GO = 8'h2f;

  // ****************************************************************
  // Argument counts and scroll setup byte positions
  // ****************************************************************
  localparam logic [2:0] ARGS_ADDR = 3'h2;
  localparam logic [2:0] ARGS_ONE = 3'h1;
  localparam logic [2:0] ARGS_SCROLL = 3'h7;
  localparam logic [2:0] SC_START_ROW = 3'h1;
  localparam logic [2:0] SC_INTERVAL = 3'h2;
  localparam logic [2:0] SC_END_ROW = 3'h3;
  localparam logic [2:0] SC_START_COL = 3'h4;
  localparam logic [2:0] SC_END_COL = 3'h5;

  // ****************************************************************
  // Remap field positions and reset values
  // ****************************************************************
  localparam int REMAP_COL_BIT = 0;
  localparam int REMAP_NIBBLE_BIT = 1;
  localparam int REMAP_VERT_BIT = 2;
  localparam int REMAP_ROWREV_BIT = 4;
  localparam int REMAP_SPLIT_BIT = 6;
  localparam logic [7:0] REMAP_RST = 8'h00;
  localparam logic [5:0] COL_START_RST = 6'h00;
  localparam logic [5:0] COL_END_RST = 6'h3f;
  localparam logic [6:0] ROW_START_RST = 7'h00;
  localparam logic [6:0] ROW_END_RST = 7'h7f;
  localparam logic [6:0] ROW_COUNT_RST = 7'h7f;
  localparam logic [6:0] START_LINE_RST = 7'h00;
  localparam logic [7:0] CONTRAST_RST = 8'h7f;
  localparam logic [2:0] INTERVAL_RST = 3'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_PERIOD_NS = 1000000;
  localparam int FRAME_CYCLES_DEF = FRAME_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [0:0] {CMD_OPCODE, CMD_ARGS} cmd_state_t;

  // Frames between two scroll steps for each interval code.
  function automatic logic [8:0] scroll_frames(input logic [2:0] code);
    logic [8:0] frames;
    unique case (code)
      3'h0: frames = 9'h006;
      3'h1: frames = 9'h020;
      3'h2: frames = 9'h040;
      3'h3: frames = 9'h100;
      3'h4: frames = 9'h003;
      3'h5: frames = 9'h004;
      3'h6: frames = 9'h005;
      3'h7: frames = 9'h002;
    endcase
    return frames;
  endfunction : scroll_frames

  // Swaps the two pixel nibbles of a byte when enabled.
  function automatic logic [7:0] nibble_map(input logic [7:0] b, input logic swap);
    return swap ? {b[3:0], b[7:4]} : b;
  endfunction : nibble_map

endpackage : disp_ram_pkg

// file: logic/addr_pointer.sv
`timescale 1ns/1ps
module addr_pointer
  import disp_ram_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic setCol,
  input wire logic setRow,
  input wire logic [6:0] startIn,
  input wire logic [6:0] endIn,
  input wire logic step,
  input wire logic vertical,
  output logic [5:0] colPtr,
  output logic [6:0] rowPtr
);

  logic [5:0] colStart_r, colStart_nxt, colEnd_r, colEnd_nxt, colPtr_r, colPtr_nxt;
  logic [6:0] rowStart_r, rowStart_nxt, rowEnd_r, rowEnd_nxt, rowPtr_r, rowPtr_nxt;

  // ****************************************************************
  // Window load and pointer advance
  // ****************************************************************
  // A window load wins over a step in the same cycle, so a fresh window always
  // starts exactly at its start corner.
  always_comb
  begin
    colStart_nxt = colStart_r;
    colEnd_nxt = colEnd_r;
    colPtr_nxt = colPtr_r;
    rowStart_nxt = rowStart_r;
    rowEnd_nxt = rowEnd_r;
    rowPtr_nxt = rowPtr_r;
    if (setCol)
    begin
      colStart_nxt = startIn[5:0];
      colEnd_nxt = endIn[5:0];
      colPtr_nxt = startIn[5:0];
    end
    else if (setRow)
    begin
      rowStart_nxt = startIn;
      rowEnd_nxt = endIn;
      rowPtr_nxt = startIn;
    end
    else if (step && !vertical)
    begin
      if (colPtr_r == colEnd_r)
      begin
        colPtr_nxt = colStart_r;
        rowPtr_nxt = (rowPtr_r == rowEnd_r) ? rowStart_r : rowPtr_r + 7'h01;
      end
      else
      begin
        colPtr_nxt = colPtr_r + 6'h01;
      end
    end
    else if (step)
    begin
      if (rowPtr_r == rowEnd_r)
      begin
        rowPtr_nxt = rowStart_r;
        colPtr_nxt = (colPtr_r == colEnd_r) ? colStart_r : colPtr_r + 6'h01;
      end
      else
      begin
        rowPtr_nxt = rowPtr_r + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      colStart_r <= COL_START_RST;
      colEnd_r <= COL_END_RST;
      colPtr_r <= COL_START_RST;
      rowStart_r <= ROW_START_RST;
      rowEnd_r <= ROW_END_RST;
      rowPtr_r <= ROW_START_RST;
    end
    else
    begin
      colStart_r <= colStart_nxt;
      colEnd_r <= colEnd_nxt;
      colPtr_r <= colPtr_nxt;
      rowStart_r <= rowStart_nxt;
      rowEnd_r <= rowEnd_nxt;
      rowPtr_r <= rowPtr_nxt;
    end
  end

  assign colPtr = colPtr_r;
  assign rowPtr = rowPtr_r;

endmodule : addr_pointer

// file: logic/row_map.sv
`timescale 1ns/1ps
module row_map
(
  input wire logic [6:0] rowOut,
  input wire logic [6:0] activeRows,
  input wire logic [6:0] startLine,
  input wire logic rowReverse,
  input wire logic oddEvenSplit,
  output logic [6:0] ramRow,
  output logic rowActive
);

  logic [6:0] pos;
  logic [7:0] half;
  logic [6:0] logical;

  // ****************************************************************
  // Row driver output to display RAM row
  // ****************************************************************
  // Reversal and splitting act on the active rows only, then the start line
  // shifts the RAM row modulo 128.
  always_comb
  begin
    rowActive = (rowOut <= activeRows);
    pos = rowReverse ? activeRows - rowOut : rowOut;
    half = ({1'b0, activeRows} + 8'h01) >> 1;
    if (oddEvenSplit)
    begin
      logical = pos[0] ? 7'(half + {2'b00, pos[6:1]}) : {1'b0, pos[6:1]};
    end
    else
    begin
      logical = pos;
    end
    ramRow = rowActive ? logical + startLine : 7'h00;
  end

endmodule : row_map

// file: tb/disp_host.sv
`timescale 1ns/1ps
// ****
// Host bus master
// ****
module disp_host
  import disp_ram_pkg::*;
(
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // The only slave stays selected; idle transfers keep it quiet.
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Single word transfer; stale write data is inverted so it never looks valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // One command or argument byte.
  task automatic cmd(input logic [7:0] b);
    logic [31:0] rd;
    xfer(1'b1, OFS_CMD, {24'h0, b}, rd);
  endtask : cmd

  // Full-window scroll setup with the start command right behind it.
  task automatic scrollSetup(input logic left, input logic [2:0] code);
    cmd(left ? OP_SCROLL_LEFT : OP_SCROLL_RIGHT);
    cmd(8'h00);
    cmd(8'h00);
    cmd({5'h0, code});
    cmd(8'h7f);
    cmd(8'h00);
    cmd(8'h3f);
    cmd(8'h00);
    cmd(OP_SCROLL_GO);
  endtask : scrollSetup
endmodule : disp_host

// file: tb/display_ram_access_control_chk.sv
`timescale 1ns/1ps
module display_ram_access_control_chk
  import disp_ram_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] hresp,
  input wire logic [6:0] scanRowOut,
  input wire logic [5:0] scanCol,
  input wire logic [7:0] scanPixel,
  input wire logic scanRowActive,
  input wire logic [7:0] contrastLevel,
  input wire logic scrollRunning
);
  // ****
  // Bus and scan checks
  // ****
  logic [1:0] phase_r, phase_nxt;
  // Bit 1 marks a write data phase, bit 0 a read data phase.
  always_comb phase_nxt = {hsel && hready && htrans[1] && hwrite,
                           hsel && hready && htrans[1] && !hwrite};
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) phase_r <= 2'h0;
    else phase_r <= phase_nxt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence rdTaken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence cmdRead;
    rdTaken ##0 (haddr[7:0] == OFS_CMD);
  endsequence

  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("hresp not okay");
  chk_rdata_stands: assert property (!$stable(hrdata) |-> phase_r[0])
    else $error("hrdata moved without a read");
  chk_cmd_reads_zero: assert property (cmdRead |=> hrdata == 32'h0)
    else $error("command read not zero");
  chk_contrast_cause: assert property (!$stable(contrastLevel) |->
    $past(phase_r[1]) && contrastLevel == $past(hwdata[7:0])) else $error("contrast moved");
  chk_scroll_go: assert property ($rose(scrollRunning) |->
    $past(phase_r[1]) && $past(hwdata[7:0]) == OP_SCROLL_GO) else $error("scroll start");
  chk_scroll_stop: assert property ($fell(scrollRunning) |->
    $past(hwdata[7:0]) == OP_SCROLL_STOP) else $error("scroll stop");
  chk_dark_row: assert property (!scanRowActive |-> scanPixel == 8'h00)
    else $error("inactive row lit");
endmodule : display_ram_access_control_chk

// file: tb/display_ram_access_control_tb.sv
`timescale 1ns/1ps
module display_ram_access_control_tb
  import disp_ram_pkg::*;
;
  // ****
  // Bench
  // ****
  localparam int FC = 4;
  typedef struct packed {logic [7:0] rm, sl, cnt, pix; logic [6:0] row; logic [5:0] col;
                         logic act;} scan_t;
  logic core_clk, reset_n, hsel, hwrite, hreadyout, scanRowActive, scrollRunning;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [6:0] scanRowOut, rs, re;
  logic [5:0] scanCol, cs, ce;
  logic [7:0] scanPixel, contrastLevel;
  logic [7:0] mem [8192];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int fr [8] = '{6, 32, 64, 256, 3, 4, 5, 2};
  scan_t tbl [7] = '{'{8'h00, 8'h00, 8'h7f, 8'h05, 7'd0, 6'd5, 1'b1},
    '{8'h01, 8'h00, 8'h7f, 8'h3a, 7'd0, 6'd5, 1'b1}, '{8'h10, 8'h00, 8'h7f, 8'h05, 7'd127, 6'd5, 1'b1},
    '{8'h00, 8'h01, 8'h7f, 8'h05, 7'd127, 6'd5, 1'b1}, '{8'h00, 8'h00, 8'h0f, 8'h00, 7'd20, 6'd5, 1'b0},
    '{8'h40, 8'h40, 8'h7f, 8'h05, 7'd1, 6'd5, 1'b1}, '{8'h00, 8'h00, 8'h7f, 8'h00, 7'd0, 6'd0, 1'b1}};

  display_ram_access_control #(.FRAME_CYCLES(FC)) dut (.hready(hreadyout), .*);
  disp_host host (.hready(hreadyout), .*);

  // Pointer after one access, for either increment mode.
  function automatic logic [12:0] nextPtr(input logic [12:0] p, input logic v);
    logic cEnd, rEnd;
    cEnd = p[5:0] == ce;
    rEnd = p[12:6] == re;
    if (v)
      return {rEnd ? rs : p[12:6] + 7'h1, rEnd ? (cEnd ? cs : p[5:0] + 6'h1) : p[5:0]};
    return {cEnd ? (rEnd ? rs : p[12:6] + 7'h1) : p[12:6], cEnd ? cs : p[5:0] + 6'h1};
  endfunction : nextPtr

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Column and row windows; both pointers load the start bounds.
  task automatic win(input logic [5:0] c0, c1, input logic [6:0] r0, r1);
    host.cmd(OP_COL_ADDR);
    host.cmd({2'h0, c0});
    host.cmd({2'h0, c1});
    host.cmd(OP_ROW_ADDR);
    host.cmd({1'h0, r0});
    host.cmd({1'h0, r1});
  endtask : win

  task automatic ptrChk(input logic [12:0] p);
    logic [31:0] d;
    host.xfer(1'b0, OFS_STATUS, 32'h0, d);
    check("pointer", d[22:8], {p[12:6], 2'h0, p[5:0]});
  endtask : ptrChk

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard far above the few thousand cycles the tests take.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [12:0] p;
    int n;
    reset_n = 1'b0;
    scanRowOut = 7'h0;
    scanCol = 6'h0;
    d = $urandom(57);
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    host.xfer(1'b0, OFS_SETUP, 32'h0, d);
    check("setup", d, 32'h7f00007f);
    host.xfer(1'b0, 8'h20, 32'h0, d);
    check("unmapped", d, 32'h0);
    host.xfer(1'b0, OFS_CMD, 32'h0, d);
    check("cmd read", d, 32'h0);
    ptrChk(13'h0);
    n = $urandom % 256;
    host.cmd(OP_CONTRAST);
    host.cmd(n[7:0]);
    for (int k = 0; k < 3; k++)
      host.cmd(OP_NOP_LO + 8'(k));
    check("contrast", contrastLevel, n[7:0]);
    $display("test contrast done");
    // Small random windows walked one access past a full lap, then read back.
    for (int v = 0; v < 2; v++)
    begin
      cs = 6'($urandom % 4);
      ce = cs + 6'(1 + $urandom % 3);
      rs = 7'($urandom % 4);
      re = rs + 7'(1 + $urandom % 2);
      host.cmd(OP_REMAP);
      host.cmd(v[0] ? 8'h06 : 8'h00);
      win(cs, ce, rs, re);
      p = {rs, cs};
      ptrChk(p);
      n = (ce - cs + 1) * (re - rs + 1) + 1;
      repeat (n)
      begin
        mem[p] = 8'($urandom);
        host.xfer(1'b1, OFS_DATA, {24'h0, mem[p]}, d);
        p = nextPtr(p, v[0]);
      end
      ptrChk(p);
      win(cs, ce, rs, re);
      host.xfer(1'b0, OFS_DATA, 32'h0, d);
      p = {rs, cs};
      repeat (n)
      begin
        host.xfer(1'b0, OFS_DATA, 32'h0, d);
        check("readback", d, {24'h0, mem[p]});
        p = nextPtr(p, v[0]);
      end
    end
    host.xfer(1'b1, OFS_CONFIG, 32'h1, d);
    host.xfer(1'b0, OFS_DATA, 32'h0, d);
    check("serial read", d, 32'h0);
    ptrChk(nextPtr(p, 1'b1));
    host.xfer(1'b1, OFS_CONFIG, 32'h0, d);
    $display("test pointer done");
    // Row 0 holds its own column numbers for the scan checks.
    host.cmd(OP_REMAP);
    host.cmd(8'h00);
    win(6'h0, 6'h3f, 7'h0, 7'h7f);
    for (int c = 0; c < 64; c++)
      host.xfer(1'b1, OFS_DATA, 32'(c), d);
    for (int k = 0; k < 7; k++)
    begin
      host.cmd(OP_REMAP);
      host.cmd(tbl[k].rm);
      host.cmd(OP_START_LINE);
      host.cmd(tbl[k].sl);
      host.cmd(OP_ROW_COUNT);
      host.cmd(tbl[k].cnt);
      @(posedge core_clk);
      scanRowOut <= tbl[k].row;
      scanCol <= tbl[k].col;
      @(posedge core_clk);
      #1;
      check("pixel", scanPixel, tbl[k].pix);
      check("active", scanRowActive, tbl[k].act);
    end
    $display("test scan done");
    for (int k = 0; k < 8; k++)
    begin
      host.scrollSetup(k[0], k[2:0]);
      #1;
      check("running", scrollRunning, 1'b1);
      repeat (fr[k] * FC - 3) @(posedge core_clk);
      #1;
      check("hold", scanPixel, 8'h00);
      repeat (6) @(posedge core_clk);
      #1;
      check("step", scanPixel, k[0] ? 8'h01 : 8'h3f);
      host.cmd(OP_SCROLL_STOP);
      #1;
      check("stopped", scrollRunning, 1'b0);
    end
    host.cmd(OP_SCROLL_GO);
    #1;
    check("lone start", scrollRunning, 1'b0);
    $display("test scroll done");
    results();
  end
endmodule : display_ram_access_control_tb

bind display_ram_access_control display_ram_access_control_chk chk (.*);
